// File: verilog/scf_regs.vh
// Constants for the statistics carry flag register bank.
// Assumes a 32-bit AXI4-Lite slave decoding the low eight address bits.
// Functional notes
// - Carry bits 31:25 hold frame-size bin carries
// - Carry bits 16:8 hold receive counter carries
// - Carry bits 6:1 receive errors; others reserved
// - First carry register resets zero, read clears
// - Second register: bits 19, 18, 16 transmit carries
// - Second register bits 15:10 transmit counter carries
// - Second register bits 8:2 deferral, collision carries
// - Second carry register resets zero, read clears
// - First mask: read/write bit per carry flag
// - First mask bits reset to one
// - Counter rollover sets its carry flag
// - Unmasked set carry raises overflow status
`ifndef SCF_REGS_VH
`define SCF_REGS_VH

// Byte addresses of the registers
`define SCF_ADDR_RX_CARRY   8'h30
`define SCF_ADDR_TX_CARRY   8'h34
`define SCF_ADDR_RX_MASK    8'h38
`define SCF_ADDR_IRQ_STATUS 8'h40
`define SCF_ADDR_IRQ_MASK   8'h44

// Defined carry positions
`define SCF_RX_CARRY_BITS   32'hfe01ff7e
`define SCF_TX_CARRY_BITS   32'h000dfdfc
`define SCF_RX_MASK_BITS    32'hfe01ffff

// Reset values
`define SCF_RX_CARRY_RST    32'h00000000
`define SCF_TX_CARRY_RST    32'h00000000
`define SCF_RX_MASK_RST     32'hfe01ffff
`define SCF_IRQ_STATUS_RST  1'b0
`define SCF_IRQ_MASK_RST    1'b0

// Field positions, first carry register and its mask
`define SCF_BIT_BIN_64          31
`define SCF_BIT_BIN_TO_127      30
`define SCF_BIT_BIN_TO_255      29
`define SCF_BIT_BIN_TO_511      28
`define SCF_BIT_BIN_TO_1K       27
`define SCF_BIT_BIN_TO_MAX      26
`define SCF_BIT_BIN_MAX_GOOD    25
`define SCF_BIT_RX_BYTES        16
`define SCF_BIT_RX_PACKETS      15
`define SCF_BIT_RX_FCS_ERR      14
`define SCF_BIT_RX_MULTICAST    13
`define SCF_BIT_RX_BROADCAST    12
`define SCF_BIT_RX_CONTROL      11
`define SCF_BIT_RX_PAUSE        10
`define SCF_BIT_RX_UNKNOWN_OP   9
`define SCF_BIT_RX_ALIGN_ERR    8
`define SCF_BIT_MASK_SPARE_HI   7
`define SCF_BIT_RX_CODE_ERR     6
`define SCF_BIT_RX_CARRIER_ERR  5
`define SCF_BIT_RX_UNDERSIZE    4
`define SCF_BIT_RX_OVERSIZE     3
`define SCF_BIT_RX_FRAGMENT     2
`define SCF_BIT_RX_JABBER       1
`define SCF_BIT_MASK_SPARE_LO   0

// Field positions, second carry register
`define SCF_BIT_TX_JABBER       19
`define SCF_BIT_TX_FCS_ERR      18
`define SCF_BIT_TX_OVERSIZE     16
`define SCF_BIT_TX_UNDERSIZE    15
`define SCF_BIT_TX_FRAGMENT     14
`define SCF_BIT_TX_BYTES        13
`define SCF_BIT_TX_PACKETS      12
`define SCF_BIT_TX_MULTICAST    11
`define SCF_BIT_TX_BROADCAST    10
`define SCF_BIT_TX_DEFERRAL     8
`define SCF_BIT_TX_EXCESS_DEFER 7
`define SCF_BIT_TX_SINGLE_COLL  6
`define SCF_BIT_TX_MULTI_COLL   5
`define SCF_BIT_TX_LATE_COLL    4
`define SCF_BIT_TX_EXCESS_COLL  3
`define SCF_BIT_TX_TOTAL_COLL   2

// Field position in the interrupt status and mask registers
`define SCF_BIT_OVERFLOW        0

// Bus responses
`define SCF_RESP_OKAY   2'b00
`define SCF_RESP_SLVERR 2'b10

`endif

// File: verilog/scf_carry_bank.v
// Carry flag, carry mask and overflow interrupt registers for the MAC statistics.
// Assumes one-cycle rollover pulses from the counters and an AXI4-Lite master.
`timescale 1ns/100ps
`default_nettype none
`include "scf_regs.vh"

module scf_carry_bank (
    // Clock and reset
    input  wire        mclk_in,
    input  wire        arst_n_in,
    // Counter rollover pulses, one bit per carry position
    input  wire [31:0] rx_rollover_in,
    input  wire [31:0] tx_rollover_in,
    // Mask for the transmit carries, held outside this block
    input  wire [31:0] tx_carry_mask_in,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid_in,
    output wire        s_axi_awready_out,
    input  wire [7:0]  s_axi_awaddr_in,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid_in,
    output wire        s_axi_wready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    // AXI4-Lite write response
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    output reg  [1:0]  s_axi_bresp_out,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid_in,
    output wire        s_axi_arready_out,
    input  wire [7:0]  s_axi_araddr_in,
    // AXI4-Lite read data
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    // Overflow status and interrupt
    output wire        stats_overflow_status_out,
    output wire        irq_out
);

    // One-hot register select: rx carry, tx carry, rx mask, irq status, irq mask
    function [4:0] scf_decode;
        input [7:0] addr;
        begin
            case ({addr[7:2], 2'b00})
                `SCF_ADDR_RX_CARRY:   scf_decode = 5'h01;
                `SCF_ADDR_TX_CARRY:   scf_decode = 5'h02;
                `SCF_ADDR_RX_MASK:    scf_decode = 5'h04;
                `SCF_ADDR_IRQ_STATUS: scf_decode = 5'h08;
                `SCF_ADDR_IRQ_MASK:   scf_decode = 5'h10;
                default:              scf_decode = 5'h00;
            endcase
        end
    endfunction

    reg  [31:0] rx_and_bin_carry_flags;
    reg  [31:0] tx_carry_flags;
    reg  [31:0] rx_and_bin_carry_masks;
    reg         stats_overflow_status;
    reg         irq_mask;

    reg         aw_held;
    reg  [7:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    wire [31:0] strb_bits;
    wire [4:0]  wr_sel;
    wire [4:0]  rd_sel;
    wire        wr_fire;
    wire        rd_fire;
    wire        rx_read_clear;
    wire        tx_read_clear;
    wire        ovf_rx_source;
    wire        ovf_tx_source;
    wire        ovf_source;
    wire        ovf_clear;

    reg  [31:0] next_rdata;
    reg  [31:0] next_rx_and_bin_carry_masks;

    // Named carry flags of the first register: frame-size bins
    wire        carry_bin_64 = rx_and_bin_carry_flags[`SCF_BIT_BIN_64];
    wire        carry_bin_to_127 = rx_and_bin_carry_flags[`SCF_BIT_BIN_TO_127];
    wire        carry_bin_to_255 = rx_and_bin_carry_flags[`SCF_BIT_BIN_TO_255];
    wire        carry_bin_to_511 = rx_and_bin_carry_flags[`SCF_BIT_BIN_TO_511];
    wire        carry_bin_to_1k = rx_and_bin_carry_flags[`SCF_BIT_BIN_TO_1K];
    wire        carry_bin_to_max = rx_and_bin_carry_flags[`SCF_BIT_BIN_TO_MAX];
    wire        carry_bin_max_good = rx_and_bin_carry_flags[`SCF_BIT_BIN_MAX_GOOD];
    // Named carry flags of the first register: receive counters
    wire        carry_rx_bytes = rx_and_bin_carry_flags[`SCF_BIT_RX_BYTES];
    wire        carry_rx_packets = rx_and_bin_carry_flags[`SCF_BIT_RX_PACKETS];
    wire        carry_rx_fcs_err = rx_and_bin_carry_flags[`SCF_BIT_RX_FCS_ERR];
    wire        carry_rx_multicast = rx_and_bin_carry_flags[`SCF_BIT_RX_MULTICAST];
    wire        carry_rx_broadcast = rx_and_bin_carry_flags[`SCF_BIT_RX_BROADCAST];
    wire        carry_rx_control = rx_and_bin_carry_flags[`SCF_BIT_RX_CONTROL];
    wire        carry_rx_pause = rx_and_bin_carry_flags[`SCF_BIT_RX_PAUSE];
    wire        carry_rx_unknown_op = rx_and_bin_carry_flags[`SCF_BIT_RX_UNKNOWN_OP];
    wire        carry_rx_align_err = rx_and_bin_carry_flags[`SCF_BIT_RX_ALIGN_ERR];
    wire        carry_rx_code_err = rx_and_bin_carry_flags[`SCF_BIT_RX_CODE_ERR];
    wire        carry_rx_carrier_err = rx_and_bin_carry_flags[`SCF_BIT_RX_CARRIER_ERR];
    wire        carry_rx_undersize = rx_and_bin_carry_flags[`SCF_BIT_RX_UNDERSIZE];
    wire        carry_rx_oversize = rx_and_bin_carry_flags[`SCF_BIT_RX_OVERSIZE];
    wire        carry_rx_fragment = rx_and_bin_carry_flags[`SCF_BIT_RX_FRAGMENT];
    wire        carry_rx_jabber = rx_and_bin_carry_flags[`SCF_BIT_RX_JABBER];

    // Named carry flags of the second register
    wire        carry_tx_jabber = tx_carry_flags[`SCF_BIT_TX_JABBER];
    wire        carry_tx_fcs_err = tx_carry_flags[`SCF_BIT_TX_FCS_ERR];
    wire        carry_tx_oversize = tx_carry_flags[`SCF_BIT_TX_OVERSIZE];
    wire        carry_tx_undersize = tx_carry_flags[`SCF_BIT_TX_UNDERSIZE];
    wire        carry_tx_fragment = tx_carry_flags[`SCF_BIT_TX_FRAGMENT];
    wire        carry_tx_bytes = tx_carry_flags[`SCF_BIT_TX_BYTES];
    wire        carry_tx_packets = tx_carry_flags[`SCF_BIT_TX_PACKETS];
    wire        carry_tx_multicast = tx_carry_flags[`SCF_BIT_TX_MULTICAST];
    wire        carry_tx_broadcast = tx_carry_flags[`SCF_BIT_TX_BROADCAST];
    wire        carry_tx_deferral = tx_carry_flags[`SCF_BIT_TX_DEFERRAL];
    wire        carry_tx_excess_defer = tx_carry_flags[`SCF_BIT_TX_EXCESS_DEFER];
    wire        carry_tx_single_coll = tx_carry_flags[`SCF_BIT_TX_SINGLE_COLL];
    wire        carry_tx_multi_coll = tx_carry_flags[`SCF_BIT_TX_MULTI_COLL];
    wire        carry_tx_late_coll = tx_carry_flags[`SCF_BIT_TX_LATE_COLL];
    wire        carry_tx_excess_coll = tx_carry_flags[`SCF_BIT_TX_EXCESS_COLL];
    wire        carry_tx_total_coll = tx_carry_flags[`SCF_BIT_TX_TOTAL_COLL];

    // The two mask bits that software sets on a reduced-pin interface
    wire        mask_rx_fcs_err = rx_and_bin_carry_masks[`SCF_BIT_RX_FCS_ERR];
    wire        mask_rx_align_err = rx_and_bin_carry_masks[`SCF_BIT_RX_ALIGN_ERR];

    // Read views built field by field, so a reserved position can never read as one
    wire [31:0] rx_carry_view = {
        // Frame-size bins, bits 31:25
        carry_bin_64,
        carry_bin_to_127,
        carry_bin_to_255,
        carry_bin_to_511,
        carry_bin_to_1k,
        carry_bin_to_max,
        carry_bin_max_good,
        // Reserved bits 24:17
        8'h00,
        // Receive counters, bits 16:8
        carry_rx_bytes,
        carry_rx_packets,
        carry_rx_fcs_err,
        carry_rx_multicast,
        carry_rx_broadcast,
        carry_rx_control,
        carry_rx_pause,
        carry_rx_unknown_op,
        carry_rx_align_err,
        // Reserved bit 7, receive errors in bits 6:1, reserved bit 0
        1'b0,
        carry_rx_code_err,
        carry_rx_carrier_err,
        carry_rx_undersize,
        carry_rx_oversize,
        carry_rx_fragment,
        carry_rx_jabber,
        1'b0
    };

    wire [31:0] tx_carry_view = {
        // Reserved bits 31:20, then bits 19, 18 and 16 around reserved bit 17
        12'h000,
        carry_tx_jabber,
        carry_tx_fcs_err,
        1'b0,
        carry_tx_oversize,
        // Size and traffic counters, bits 15:10
        carry_tx_undersize,
        carry_tx_fragment,
        carry_tx_bytes,
        carry_tx_packets,
        carry_tx_multicast,
        carry_tx_broadcast,
        // Reserved bit 9, deferral and collisions in bits 8:2, reserved 1:0
        1'b0,
        carry_tx_deferral,
        carry_tx_excess_defer,
        carry_tx_single_coll,
        carry_tx_multi_coll,
        carry_tx_late_coll,
        carry_tx_excess_coll,
        carry_tx_total_coll,
        2'b00
    };

    // Mask bits sit at their carry positions; bits 7 and 0 keep what software wrote
    wire [31:0] rx_mask_view = {
        // Frame-size bins
        rx_and_bin_carry_masks[`SCF_BIT_BIN_64],
        rx_and_bin_carry_masks[`SCF_BIT_BIN_TO_127],
        rx_and_bin_carry_masks[`SCF_BIT_BIN_TO_255],
        rx_and_bin_carry_masks[`SCF_BIT_BIN_TO_511],
        rx_and_bin_carry_masks[`SCF_BIT_BIN_TO_1K],
        rx_and_bin_carry_masks[`SCF_BIT_BIN_TO_MAX],
        rx_and_bin_carry_masks[`SCF_BIT_BIN_MAX_GOOD],
        8'h00,
        // Receive counters
        rx_and_bin_carry_masks[`SCF_BIT_RX_BYTES],
        rx_and_bin_carry_masks[`SCF_BIT_RX_PACKETS],
        mask_rx_fcs_err,
        rx_and_bin_carry_masks[`SCF_BIT_RX_MULTICAST],
        rx_and_bin_carry_masks[`SCF_BIT_RX_BROADCAST],
        rx_and_bin_carry_masks[`SCF_BIT_RX_CONTROL],
        rx_and_bin_carry_masks[`SCF_BIT_RX_PAUSE],
        rx_and_bin_carry_masks[`SCF_BIT_RX_UNKNOWN_OP],
        mask_rx_align_err,
        // Receive errors between the two spare bits
        rx_and_bin_carry_masks[`SCF_BIT_MASK_SPARE_HI],
        rx_and_bin_carry_masks[`SCF_BIT_RX_CODE_ERR],
        rx_and_bin_carry_masks[`SCF_BIT_RX_CARRIER_ERR],
        rx_and_bin_carry_masks[`SCF_BIT_RX_UNDERSIZE],
        rx_and_bin_carry_masks[`SCF_BIT_RX_OVERSIZE],
        rx_and_bin_carry_masks[`SCF_BIT_RX_FRAGMENT],
        rx_and_bin_carry_masks[`SCF_BIT_RX_JABBER],
        rx_and_bin_carry_masks[`SCF_BIT_MASK_SPARE_LO]
    };

    // Byte strobes widened to bit enables
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_strb
            assign strb_bits[lane*8 +: 8] = {8{w_strb[lane]}};
        end
    endgenerate

    // Write waits for both address and data; holding them keeps either order legal
    assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
    assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
    assign s_axi_arready_out = !s_axi_rvalid_out;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;
    assign rd_fire = s_axi_arvalid_in && !s_axi_rvalid_out;
    assign wr_sel  = scf_decode(aw_addr);
    assign rd_sel  = scf_decode(s_axi_araddr_in);

    assign rx_read_clear = rd_fire && rd_sel[0];
    assign tx_read_clear = rd_fire && rd_sel[1];

    // Carry bits without a mask bit set feed the overflow status
    assign ovf_rx_source = |(rx_and_bin_carry_flags & ~rx_and_bin_carry_masks
                             & `SCF_RX_CARRY_BITS);
    assign ovf_tx_source = |(tx_carry_flags & ~tx_carry_mask_in
                             & `SCF_TX_CARRY_BITS);
    assign ovf_source    = ovf_rx_source | ovf_tx_source;
    assign ovf_clear  = wr_fire && wr_sel[3] && w_strb[0] && w_data[`SCF_BIT_OVERFLOW];

    assign stats_overflow_status_out = stats_overflow_status;
    assign irq_out = stats_overflow_status && !irq_mask;

    always @* begin
        case (rd_sel)
            5'h01:   next_rdata = rx_carry_view;
            5'h02:   next_rdata = tx_carry_view;
            5'h04:   next_rdata = rx_mask_view;
            5'h08:   next_rdata = {31'h00000000, stats_overflow_status};
            5'h10:   next_rdata = {31'h00000000, irq_mask};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Bits 7 and 0 are stored so they read back the ones software writes there
    always @* begin
        next_rx_and_bin_carry_masks = rx_and_bin_carry_masks;
        if (wr_fire && wr_sel[2]) begin
            next_rx_and_bin_carry_masks =
                (rx_and_bin_carry_masks & ~(strb_bits & `SCF_RX_MASK_BITS))
                | (w_data & strb_bits & `SCF_RX_MASK_BITS);
        end
    end

    // Bus handshake state
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_held          <= 1'b0;
            aw_addr          <= 8'h00;
            w_held           <= 1'b0;
            w_data           <= 32'h00000000;
            w_strb           <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= `SCF_RESP_OKAY;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h00000000;
            s_axi_rresp_out  <= `SCF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (wr_sel == 5'h00) ? `SCF_RESP_SLVERR : `SCF_RESP_OKAY;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= next_rdata;
                s_axi_rresp_out  <= (rd_sel == 5'h00) ? `SCF_RESP_SLVERR : `SCF_RESP_OKAY;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // Carry flags: a rollover in the clearing cycle wins, so no event is lost
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_and_bin_carry_flags <= `SCF_RX_CARRY_RST;
            tx_carry_flags         <= `SCF_TX_CARRY_RST;
        end else begin
            rx_and_bin_carry_flags <=
                ((rx_read_clear ? 32'h00000000 : rx_and_bin_carry_flags)
                 | rx_rollover_in) & `SCF_RX_CARRY_BITS;
            tx_carry_flags <=
                ((tx_read_clear ? 32'h00000000 : tx_carry_flags)
                 | tx_rollover_in) & `SCF_TX_CARRY_BITS;
        end
    end

    // Mask and interrupt registers
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_and_bin_carry_masks <= `SCF_RX_MASK_RST;
            stats_overflow_status  <= `SCF_IRQ_STATUS_RST;
            irq_mask               <= `SCF_IRQ_MASK_RST;
        end else begin
            rx_and_bin_carry_masks <= next_rx_and_bin_carry_masks;
            stats_overflow_status  <= ovf_source
                                    | (stats_overflow_status && !ovf_clear);
            if (wr_fire && wr_sel[4] && w_strb[0]) begin
                irq_mask <= w_data[0];
            end
        end
    end

endmodule // scf_carry_bank

`default_nettype wire

// File: dv/scf_carry_bank_sva.sv
// Port-level checker for the carry flag bank.
// Assumes the bank's register map header and a single clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "scf_regs.vh"
module scf_carry_bank_sva (
    // Clock, reset and events
    input wire        mclk_in, arst_n_in, stats_overflow_status_out, irq_out,
    input wire [31:0] tx_rollover_in, tx_carry_mask_in, s_axi_rdata_out,
    // Bus handshakes
    input wire        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out,
    input wire        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out,
    input wire        s_axi_rvalid_out, s_axi_rready_in,
    input wire [1:0]  s_axi_bresp_out,
    input wire [7:0]  s_axi_araddr_in
);
    reg [7:0] rd_addr;
    // Read data carries no address, so remember the one taken
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) rd_addr <= 8'h00;
        else if (s_axi_arvalid_in && s_axi_arready_out) rd_addr <= s_axi_araddr_in;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    a_irq_needs_status: assert property (irq_out |-> stats_overflow_status_out)
        else $error("irq without status");
    a_tx_raises_status: assert property (|(tx_rollover_in & `SCF_TX_CARRY_BITS & ~tx_carry_mask_in)
        |-> ##[1:2] stats_overflow_status_out) else $error("status not raised");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read not answered");
    a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write not answered");
    a_rdata_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
        && $stable(s_axi_rdata_out)) else $error("read data dropped");
    a_bresp_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
        && $stable(s_axi_bresp_out)) else $error("write response dropped");
    a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read taken while answer pending");
    a_rx_reserved_zero: assert property (s_axi_rvalid_out && rd_addr == `SCF_ADDR_RX_CARRY
        |-> (s_axi_rdata_out & ~`SCF_RX_CARRY_BITS) == 32'h0) else $error("rx reserved bit set");
    a_tx_reserved_zero: assert property (s_axi_rvalid_out && rd_addr == `SCF_ADDR_TX_CARRY
        |-> (s_axi_rdata_out & ~`SCF_TX_CARRY_BITS) == 32'h0) else $error("tx reserved bit set");
    c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
    c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out == `SCF_RESP_SLVERR);
    c_irq: cover property (irq_out);
endmodule // scf_carry_bank_sva
bind scf_carry_bank scf_carry_bank_sva u_scf_carry_bank_sva (.*);
`default_nettype wire

// File: dv/tb_scf_carry_bank.sv
// Self-checking bench for the carry flag bank over its AXI4-Lite port.
// Assumes the bank's register map header; byte strobes are all ones but in one lane test.
`timescale 1ns/100ps
`default_nettype none
`include "scf_regs.vh"
module tb_scf_carry_bank;
    localparam logic [1:0] rok = `SCF_RESP_OKAY, rerr = `SCF_RESP_SLVERR;
    localparam logic [7:0] ad_rxc = `SCF_ADDR_RX_CARRY, ad_txc = `SCF_ADDR_TX_CARRY;
    localparam logic [7:0] ad_msk = `SCF_ADDR_RX_MASK, ad_sts = `SCF_ADDR_IRQ_STATUS;
    logic        mclk_in = 1'b0, arst_n_in = 1'b0;
    logic [31:0] rx_roll = 32'h0, tx_roll = 32'h0, tx_mask = 32'hffffffff, wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [3:0]  wstrb = 4'hf;
    wire         awready, wready, bvalid, arready, rvalid, status, irq;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    int          mismatches = 0, cmp_count = 0, cyc = 0;
    always #4 mclk_in = ~mclk_in;
    scf_carry_bank u_scf_carry_bank (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .rx_rollover_in(rx_roll), .tx_rollover_in(tx_roll), .tx_carry_mask_in(tx_mask),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .stats_overflow_status_out(status), .irq_out(irq));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge mclk_in);
        awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= d; bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge mclk_in);
            if (awvalid && awready) begin aw_done = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready) begin w_done = 1'b1; wvalid <= 1'b0; end
        end
        while (!bvalid) @(posedge mclk_in);
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask
    // The rollover rides with the read request so both land on the same edge
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
            input logic [31:0] roll);
        @(posedge mclk_in);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1; rx_roll <= roll;
        @(posedge mclk_in);
        while (!arready) @(posedge mclk_in);
        arvalid <= 1'b0; rx_roll <= 32'h0;
        while (!rvalid) @(posedge mclk_in);
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask
    task pulse(input logic [31:0] r, input logic [31:0] t);
        @(posedge mclk_in);
        rx_roll <= r; tx_roll <= t;
        @(posedge mclk_in);
        rx_roll <= 32'h0; tx_roll <= 32'h0;
        repeat (3) @(posedge mclk_in);
    endtask
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        rd(ad_msk, `SCF_RX_MASK_RST, rok, 32'h0);
        rd(ad_rxc, 32'h0, rok, 32'h0);
        rd(ad_txc, 32'h0, rok, 32'h0);
        pulse(32'hffffffff, 32'h0);
        chk({31'h0, status}, 32'h0);
        rd(ad_rxc, `SCF_RX_CARRY_BITS, rok, 32'h0);
        rd(ad_rxc, 32'h0, rok, 32'h0);
        pulse(32'h0, 32'hffffffff);
        rd(ad_txc, `SCF_TX_CARRY_BITS, rok, 32'h0);
        rd(ad_txc, 32'h0, rok, 32'h0);
        rd(ad_rxc, 32'h0, rok, 32'h02000000);
        rd(ad_rxc, 32'h02000000, rok, 32'h0);
        wr(ad_msk, 32'hffffffff, rok);
        rd(ad_msk, `SCF_RX_MASK_BITS, rok, 32'h0);
        wstrb <= 4'h1;
        wr(ad_msk, 32'h00000081, rok);
        wstrb <= 4'hf;
        rd(ad_msk, 32'hfe01ff81, rok, 32'h0);
        wr(ad_msk, 32'h00000081, rok);
        rd(ad_msk, 32'h00000081, rok, 32'h0);
        pulse(32'h00000100, 32'h0);
        chk({30'h0, status, irq}, 32'h3);
        rd(ad_rxc, 32'h00000100, rok, 32'h0);
        wr(ad_sts, 32'h1, rok);
        chk({30'h0, status, irq}, 32'h0);
        wr(ad_msk, 32'h00004181, rok);
        pulse(32'h00004100, 32'h0);
        chk({30'h0, status, irq}, 32'h0);
        rd(ad_rxc, 32'h00004100, rok, 32'h0);
        wr(`SCF_ADDR_IRQ_MASK, 32'h1, rok);
        tx_mask <= 32'hfff7ffff;
        pulse(32'h0, 32'h00080000);
        chk({30'h0, status, irq}, 32'h2);
        rd(ad_sts, 32'h1, rok, 32'h0);
        tx_mask <= 32'hffffffff;
        rd(ad_txc, 32'h00080000, rok, 32'h0);
        wr(ad_sts, 32'h1, rok);
        chk({31'h0, status}, 32'h0);
        rd(8'h3c, 32'h0, rerr, 32'h0);
        wr(8'h3c, 32'hffffffff, rerr);
        wr(ad_msk, 32'hffffffff, rok);
        pulse(32'hffffffff, 32'h0);
        chk({31'h0, status}, 32'h0);
        rd(ad_rxc, `SCF_RX_CARRY_BITS, rok, 32'h0);
        stop_test();
    end
endmodule // tb_scf_carry_bank
`default_nettype wire
